/* verilog/live_status_params.svh */
/*
  Offsets, field positions, reset values and counts of the live status bank.
  Assumes inclusion by bare name from every file that needs them.
*/
`ifndef LIVE_STATUS_PARAMS_SVH
`define LIVE_STATUS_PARAMS_SVH

// ****************************************
// Register indexes (byte address is four times the index)
// ****************************************
`define LS_IDX_GLOBAL 8'h25
`define LS_IDX_STEPDN 8'h26
`define LS_IDX_STEPUP 8'h27
`define LS_IDX_MONITOR 8'h28
`define LS_IDX_EVENT 8'h30
`define LS_IDX_MASK 8'h31
`define LS_ADDR_W 10
`define LS_REG_W 8
`define LS_STATUS_RST 8'h00
`define LS_EVENT_RST 4'h0
`define LS_MASK_RST 4'h0
`define LS_EVENT_BITS 4

// ****************************************
// Field positions
// ****************************************
`define LS_BIT_SYNC_BAD 3
`define LS_BIT_TSD 2
`define LS_BIT_TWARN 1
`define LS_BIT_OVP 0
`define LS_BIT_SD2_EN 7
`define LS_BIT_SD2_OK 6
`define LS_BIT_SD2_ILIM 4
`define LS_BIT_SD1_EN 3
`define LS_BIT_SD1_OK 2
`define LS_BIT_SD1_ILIM 0
`define LS_BIT_SU_EN 3
`define LS_BIT_SU_OK 2
`define LS_BIT_SU_ILIM 0
`define LS_BIT_MON2 4
`define LS_BIT_MON1 2
`define LS_BIT_ANA 0

// ****************************************
// Event bit positions and timing
// ****************************************
`define LS_EVT_GLOBAL 0
`define LS_EVT_STEPDN 1
`define LS_EVT_STEPUP 2
`define LS_EVT_MONITOR 3
`define LS_SYNC_STAGES 2
`define LS_PIN_COUNT 16

`endif

/* verilog/live_status_pkg.sv */
/*
  Types shared by the live status bank.
  Assumes nothing beyond the params header.
*/
package live_status_pkg;

  typedef enum logic [2:0] {
    SEL_NONE = 3'b000,
    SEL_GLOBAL = 3'b001,
    SEL_STEPDN = 3'b010,
    SEL_STEPUP = 3'b011,
    SEL_MONITOR = 3'b100,
    SEL_EVENT = 3'b101,
    SEL_MASK = 3'b110
  } reg_sel_t;

  typedef enum logic {
    BUS_IDLE = 1'b0,
    BUS_ANSWER = 1'b1
  } bus_state_t;

endpackage : live_status_pkg

/* verilog/status_sync.sv */
/*
  Two-stage synchroniser for a vector of asynchronous condition pins.
  Assumes each bit is a slow level; bits are not coherent with each other.
*/
`timescale 1ns/1ps

module status_sync #(
  parameter int WIDTH = 16
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  // ****************************************
  // One pair of flops per bit
  // ****************************************
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_bit
      logic meta_q;
      logic safe_q;
      always_ff @(posedge clk_in) begin
        if (rst_in) begin
          meta_q <= 1'b0;
          safe_q <= 1'b0;
        end else if (ce_in) begin
          meta_q <= async_in[g];
          safe_q <= meta_q;
        end
      end
      assign sync_out[g] = safe_q;
    end
  endgenerate

endmodule : status_sync

/* verilog/status_event_bank.sv */
/*
  Sticky event bits, write-one-to-clear, with mask and level interrupt.
  Assumes set and clear pulses come from logic on the same clock.
*/
`timescale 1ns/1ps
`include "live_status_params.svh"

module status_event_bank #(
  parameter int N = 4
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic [N-1:0] set_in,
  input wire logic [N-1:0] clr_in,
  input wire logic mask_we_in,
  input wire logic [N-1:0] mask_in,
  output logic [N-1:0] status_out,
  output logic [N-1:0] mask_out,
  output logic irq_out
);

  logic [N-1:0] status_q;
  logic [N-1:0] status_d;
  logic [N-1:0] mask_q;
  logic [N-1:0] mask_d;
  logic irq_q;

  // Set beats clear so no event is lost
  assign status_d = (status_q & ~clr_in) | set_in;
  assign mask_d = mask_we_in ? mask_in : mask_q;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      status_q <= N'(`LS_EVENT_RST);
    end else if (ce_in) begin
      status_q <= status_d;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      mask_q <= N'(`LS_MASK_RST);
    end else if (ce_in) begin
      mask_q <= mask_d;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      irq_q <= 1'b0;
    end else if (ce_in) begin
      irq_q <= |(status_d & mask_d);
    end
  end

  assign status_out = status_q;
  assign mask_out = mask_q;
  assign irq_out = irq_q;

endmodule : status_event_bank

/* verilog/live_status_regs.sv */
/*
  Live condition status bank of a converter supervisor, Avalon-MM slave.
  Assumes condition pins are asynchronous levels and one 250 MHz clock.
*/
// The Avalon-MM interface to the registers was chosen for this implementation.
// Contract
// - Four read-only zero-reset registers at 25h-28h
// - Global bit 3 high when sync clock invalid
// - Global bit 2 high above shutdown temperature
// - Global bit 1 high above warning temperature
// - Global bit 0 high on input overvoltage
// - Step-down bit 7: second converter enabled
// - Step-down bit 6: second converter output valid
// - Good and limit bits follow live, unlatched
// - Step-down bit 4: second converter current limit
// - Step-down bit 3: first converter enabled
// - Step-down bit 2: first converter output valid
// - Step-down bit 0: first converter current limit
// - Step-up bit 3: converter enabled
// - Step-up bit 2: output valid
// - Step-up bit 0: current limit
// - Monitor bits 4,2,0 valid; others zero
`timescale 1ns/1ps
`include "live_status_params.svh"

module live_status_regs (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic [`LS_ADDR_W-1:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  input wire logic sync_clock_invalid_in,
  input wire logic thermal_shutdown_flag_in,
  input wire logic thermal_warning_flag_in,
  input wire logic input_overvoltage_flag_in,
  input wire logic second_stepdown_enabled_flag_in,
  input wire logic second_stepdown_output_ok_flag_in,
  input wire logic second_stepdown_current_limit_flag_in,
  input wire logic first_stepdown_enabled_flag_in,
  input wire logic first_stepdown_output_ok_flag_in,
  input wire logic first_stepdown_current_limit_flag_in,
  input wire logic stepup_enabled_flag_in,
  input wire logic stepup_output_ok_flag_in,
  input wire logic stepup_current_limit_flag_in,
  input wire logic second_monitor_ok_flag_in,
  input wire logic first_monitor_ok_flag_in,
  input wire logic analog_supply_ok_flag_in,
  output logic irq_out
);
  import live_status_pkg::*;

  // ****************************************
  // Declarations
  // ****************************************
  logic [`LS_PIN_COUNT-1:0] pins_raw;
  logic [`LS_PIN_COUNT-1:0] pins_sync;
  logic [`LS_REG_W-1:0] global_q;
  logic [`LS_REG_W-1:0] global_d;
  logic [`LS_REG_W-1:0] stepdn_q;
  logic [`LS_REG_W-1:0] stepdn_d;
  logic [`LS_REG_W-1:0] stepup_q;
  logic [`LS_REG_W-1:0] stepup_d;
  logic [`LS_REG_W-1:0] monitor_q;
  logic [`LS_REG_W-1:0] monitor_d;
  logic [`LS_EVENT_BITS-1:0] evt_set;
  logic [`LS_EVENT_BITS-1:0] evt_clr;
  logic [`LS_EVENT_BITS-1:0] evt_status;
  logic [`LS_EVENT_BITS-1:0] evt_mask;
  logic mask_we;
  bus_state_t bus_q;
  bus_state_t bus_d;
  logic [31:0] rdata_q;
  logic req;
  logic accept;
  reg_sel_t sel;

  // ****************************************
  // Address decode
  // ****************************************
  // Misaligned addresses decode as unmapped rather than aliasing
  function automatic reg_sel_t sel_of(input logic [`LS_ADDR_W-1:0] addr);
    logic [7:0] idx;
    idx = addr[`LS_ADDR_W-1:2];
    if (addr[1:0] != 2'b00) begin
      return SEL_NONE;
    end
    case (idx)
      `LS_IDX_GLOBAL: return SEL_GLOBAL;
      `LS_IDX_STEPDN: return SEL_STEPDN;
      `LS_IDX_STEPUP: return SEL_STEPUP;
      `LS_IDX_MONITOR: return SEL_MONITOR;
      `LS_IDX_EVENT: return SEL_EVENT;
      `LS_IDX_MASK: return SEL_MASK;
      default: return SEL_NONE;
    endcase
  endfunction : sel_of

  assign sel = sel_of(avs_address_in);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  assign pins_raw = {
    sync_clock_invalid_in,
    thermal_shutdown_flag_in,
    thermal_warning_flag_in,
    input_overvoltage_flag_in,
    second_stepdown_enabled_flag_in,
    second_stepdown_output_ok_flag_in,
    second_stepdown_current_limit_flag_in,
    first_stepdown_enabled_flag_in,
    first_stepdown_output_ok_flag_in,
    first_stepdown_current_limit_flag_in,
    stepup_enabled_flag_in,
    stepup_output_ok_flag_in,
    stepup_current_limit_flag_in,
    second_monitor_ok_flag_in,
    first_monitor_ok_flag_in,
    analog_supply_ok_flag_in
  };

  status_sync #(
    .WIDTH(`LS_PIN_COUNT)
  ) u_sync (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .ce_in(ce_in),
    .async_in(pins_raw),
    .sync_out(pins_sync)
  );

  // ****************************************
  // Live register images
  // ****************************************
  // Unused positions stay at the reset value, so reserved bits read zero
  always_comb begin
    global_d = `LS_STATUS_RST;
    global_d[`LS_BIT_SYNC_BAD] = pins_sync[15];
    global_d[`LS_BIT_TSD] = pins_sync[14];
    global_d[`LS_BIT_TWARN] = pins_sync[13];
    global_d[`LS_BIT_OVP] = pins_sync[12];
  end

  always_comb begin
    stepdn_d = `LS_STATUS_RST;
    stepdn_d[`LS_BIT_SD2_EN] = pins_sync[11];
    stepdn_d[`LS_BIT_SD2_OK] = pins_sync[10];
    stepdn_d[`LS_BIT_SD2_ILIM] = pins_sync[9];
    stepdn_d[`LS_BIT_SD1_EN] = pins_sync[8];
    stepdn_d[`LS_BIT_SD1_OK] = pins_sync[7];
    stepdn_d[`LS_BIT_SD1_ILIM] = pins_sync[6];
  end

  always_comb begin
    stepup_d = `LS_STATUS_RST;
    stepup_d[`LS_BIT_SU_EN] = pins_sync[5];
    stepup_d[`LS_BIT_SU_OK] = pins_sync[4];
    stepup_d[`LS_BIT_SU_ILIM] = pins_sync[3];
  end

  always_comb begin
    monitor_d = `LS_STATUS_RST;
    monitor_d[`LS_BIT_MON2] = pins_sync[2];
    monitor_d[`LS_BIT_MON1] = pins_sync[1];
    monitor_d[`LS_BIT_ANA] = pins_sync[0];
  end

  // Reloaded every enabled cycle, held only while enable is low: images track the detectors
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      global_q <= `LS_STATUS_RST;
      stepdn_q <= `LS_STATUS_RST;
      stepup_q <= `LS_STATUS_RST;
      monitor_q <= `LS_STATUS_RST;
    end else if (ce_in) begin
      global_q <= global_d;
      stepdn_q <= stepdn_d;
      stepup_q <= stepup_d;
      monitor_q <= monitor_d;
    end
  end

  // ****************************************
  // Change events and interrupt
  // ****************************************
  assign evt_set[`LS_EVT_GLOBAL] = global_d != global_q;
  assign evt_set[`LS_EVT_STEPDN] = stepdn_d != stepdn_q;
  assign evt_set[`LS_EVT_STEPUP] = stepup_d != stepup_q;
  assign evt_set[`LS_EVT_MONITOR] = monitor_d != monitor_q;

  assign evt_clr = (accept && avs_write_in && sel == SEL_EVENT && avs_byteenable_in[0]) ?
    avs_writedata_in[`LS_EVENT_BITS-1:0] : `LS_EVENT_RST;
  assign mask_we = accept && avs_write_in && sel == SEL_MASK && avs_byteenable_in[0];

  status_event_bank #(
    .N(`LS_EVENT_BITS)
  ) u_events (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .ce_in(ce_in),
    .set_in(evt_set),
    .clr_in(evt_clr),
    .mask_we_in(mask_we),
    .mask_in(avs_writedata_in[`LS_EVENT_BITS-1:0]),
    .status_out(evt_status),
    .mask_out(evt_mask),
    .irq_out(irq_out)
  );

  // ****************************************
  // Avalon-MM slave: one wait state per access
  // ****************************************
  assign req = avs_read_in || avs_write_in;
  assign accept = req && bus_q == BUS_ANSWER;
  assign avs_waitrequest_out = req && bus_q != BUS_ANSWER;

  always_comb begin
    case (bus_q)
      BUS_IDLE: bus_d = req ? BUS_ANSWER : BUS_IDLE;
      BUS_ANSWER: bus_d = BUS_IDLE;
      default: bus_d = BUS_IDLE;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      bus_q <= BUS_IDLE;
    end else if (ce_in) begin
      bus_q <= bus_d;
    end
  end

  // Data is caught in the wait state so it stands at the accept edge
  // Reading changes only the bus state and read data, not images, events or mask; status writes fall through
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      rdata_q <= 32'h0000_0000;
    end else if (ce_in && avs_read_in && bus_q == BUS_IDLE) begin
      case (sel)
        SEL_GLOBAL: rdata_q <= {24'h00_0000, global_q};
        SEL_STEPDN: rdata_q <= {24'h00_0000, stepdn_q};
        SEL_STEPUP: rdata_q <= {24'h00_0000, stepup_q};
        SEL_MONITOR: rdata_q <= {24'h00_0000, monitor_q};
        SEL_EVENT: rdata_q <= {28'h000_0000, evt_status};
        SEL_MASK: rdata_q <= {28'h000_0000, evt_mask};
        default: rdata_q <= 32'h0000_0000;
      endcase
    end
  end

  assign avs_readdata_out = rdata_q;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in);

  // Counts consecutive enabled edges since reset or enable low, saturating at three
  logic [1:0] run_q;
  always_ff @(posedge clk_in) begin
    if (rst_in || !ce_in) begin
      run_q <= 2'd0;
    end else if (run_q != 2'd3) begin
      run_q <= run_q + 2'd1;
    end
  end

  a_reset_zero: assert property (disable iff (1'b0)
    $past(rst_in) |-> (global_q | stepdn_q | stepup_q | monitor_q) == 8'h00)
    else $error("status image not zero after reset");

  a_sync_bad_bit: assert property (
    run_q == 2'd3 |-> global_q[3] == $past(sync_clock_invalid_in, 3))
    else $error("sync clock bit does not follow pin");

  a_shutdown_bit: assert property (
    run_q == 2'd3 |-> global_q[2] == $past(thermal_shutdown_flag_in, 3))
    else $error("shutdown bit does not follow pin");

  a_warning_bit: assert property (
    run_q == 2'd3 |-> global_q[1] == $past(thermal_warning_flag_in, 3))
    else $error("warning bit does not follow pin");

  a_overvolt_bit: assert property (
    run_q == 2'd3 |-> global_q[0] == $past(input_overvoltage_flag_in, 3))
    else $error("overvoltage bit does not follow pin");

  a_second_enable: assert property (
    run_q == 2'd3 |-> stepdn_q[7] == $past(second_stepdown_enabled_flag_in, 3))
    else $error("second step-down enable bit wrong");

  a_second_good: assert property (
    run_q == 2'd3 |-> stepdn_q[6] == $past(second_stepdown_output_ok_flag_in, 3))
    else $error("second step-down good bit wrong");

  a_limit_live: assert property (
    run_q == 2'd3 && $past(first_stepdown_current_limit_flag_in, 3)
    ##1 run_q == 2'd3 && !$past(first_stepdown_current_limit_flag_in, 3)
    |-> !stepdn_q[0])
    else $error("current limit bit held after condition left");

  a_second_limit: assert property (
    run_q == 2'd3 |-> stepdn_q[4] == $past(second_stepdown_current_limit_flag_in, 3))
    else $error("second step-down limit bit wrong");

  a_first_good: assert property (
    run_q == 2'd3 |-> stepdn_q[2] == $past(first_stepdown_output_ok_flag_in, 3))
    else $error("first step-down good bit wrong");

  a_stepup_enable: assert property (
    run_q == 2'd3 |-> stepup_q[3] == $past(stepup_enabled_flag_in, 3))
    else $error("step-up enable bit wrong");

  a_stepup_good: assert property (
    run_q == 2'd3 |-> stepup_q[2] == $past(stepup_output_ok_flag_in, 3))
    else $error("step-up good bit wrong");

  a_monitor_map: assert property (
    run_q == 2'd3 |-> monitor_q == {3'h0, $past(second_monitor_ok_flag_in, 3), 1'b0,
      $past(first_monitor_ok_flag_in, 3), 1'b0, $past(analog_supply_ok_flag_in, 3)})
    else $error("monitor register layout wrong");

  a_reserved_zero: assert property (
    global_q[7:4] == 4'h0 && stepdn_q[5] == 1'b0 && stepdn_q[1] == 1'b0 &&
    stepup_q[7:4] == 4'h0 && stepup_q[1] == 1'b0)
    else $error("reserved status bit set");

  a_read_answer: assert property (
    avs_read_in && bus_q == BUS_IDLE && ce_in && sel == SEL_STEPDN
    |=> !avs_waitrequest_out && avs_readdata_out == {24'h00_0000, $past(stepdn_q)})
    else $error("step-down read answer wrong");

  // Enable low must hold the global and step-down images, bus state and read data alike
  a_enable_freeze: assert property (
    !ce_in |=> $stable(global_q) && $stable(stepdn_q) && $stable(bus_q) && $stable(rdata_q))
    else $error("state moved while enable low");

  c_read_global: cover property (accept && avs_read_in && sel == SEL_GLOBAL);
  c_write_status: cover property (accept && avs_write_in && sel == SEL_STEPUP);
  c_irq_raise: cover property (!irq_out ##1 irq_out);
  c_enable_resume: cover property (!ce_in ##1 ce_in);

endmodule : live_status_regs

/* sim/condition_source_model.sv */
/*
  Far-side model of the sixteen live condition detectors of the supervisor.
  Assumes the bench hands it a target level vector; the pins follow it with
  a skew that is unrelated to the clock, as real analog comparators would.
*/
`timescale 1ns/1ps

module condition_source_model #(
  parameter real SKEW_NS = 1.7
) (
  input wire logic [15:0] level_in,
  output logic [15:0] pins_out
);
  // ****************************************
  // Detector outputs
  // ****************************************
  // Off-edge skew so the design's synchroniser sees truly async levels
  initial pins_out = 16'h0000;
  always @(level_in) pins_out <= #(SKEW_NS) level_in;
endmodule : condition_source_model

/* sim/pmic_live_status_registers_tb_top.sv */
/*
  Self-checking bench of the live status bank: Avalon-MM reads and writes,
  condition pin patterns, event and interrupt handling.
  Assumes one 250 MHz clock and the designer's one-wait-state bus answer.
*/
`timescale 1ns/1ps
`include "live_status_params.svh"
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin num_errors++; \
  $display("mismatch %s expected %0h seen %0h", nm, ex, got); end end

module pmic_live_status_registers_tb_top;
  import live_status_pkg::*;

  // ****************************************
  // Signals
  // ****************************************
  logic clk_in, rst_in, ce_in, rd, wr;
  logic [9:0] addr;
  logic [31:0] wdata;
  logic [15:0] target;
  wire logic [31:0] rdata;
  wire logic [15:0] pins;
  wire logic waitreq, irq;
  int num_errors, cmp_count, cycles;

  condition_source_model src (.level_in(target), .pins_out(pins));

  live_status_regs DUT (
    .clk_in(clk_in), .rst_in(rst_in), .ce_in(ce_in),
    .avs_address_in(addr), .avs_read_in(rd), .avs_write_in(wr),
    .avs_writedata_in(wdata), .avs_byteenable_in(4'hF),
    .avs_readdata_out(rdata), .avs_waitrequest_out(waitreq),
    .sync_clock_invalid_in(pins[15]), .thermal_shutdown_flag_in(pins[14]),
    .thermal_warning_flag_in(pins[13]), .input_overvoltage_flag_in(pins[12]),
    .second_stepdown_enabled_flag_in(pins[11]),
    .second_stepdown_output_ok_flag_in(pins[10]),
    .second_stepdown_current_limit_flag_in(pins[9]),
    .first_stepdown_enabled_flag_in(pins[8]),
    .first_stepdown_output_ok_flag_in(pins[7]),
    .first_stepdown_current_limit_flag_in(pins[6]),
    .stepup_enabled_flag_in(pins[5]), .stepup_output_ok_flag_in(pins[4]),
    .stepup_current_limit_flag_in(pins[3]), .second_monitor_ok_flag_in(pins[2]),
    .first_monitor_ok_flag_in(pins[1]), .analog_supply_ok_flag_in(pins[0]),
    .irq_out(irq)
  );

  // ****************************************
  // Clock, timeout, verdict
  // ****************************************
  initial begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : end_sim

  // Whole run needs about 650 cycles; some thirty times that means a hang
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      end_sim();
    end
  end

  // ****************************************
  // Expected register images
  // ****************************************
  function automatic logic [31:0] exp_reg(input logic [7:0] idx, input logic [15:0] p);
    logic [31:0] r;
    r = 32'h0000_0000;
    case (idx)
      `LS_IDX_GLOBAL: r[3:0] = {p[15], p[14], p[13], p[12]};
      `LS_IDX_STEPDN: begin
        r[`LS_BIT_SD2_EN] = p[11];
        r[`LS_BIT_SD2_OK] = p[10];
        r[`LS_BIT_SD2_ILIM] = p[9];
        r[`LS_BIT_SD1_EN] = p[8];
        r[`LS_BIT_SD1_OK] = p[7];
        r[`LS_BIT_SD1_ILIM] = p[6];
      end
      `LS_IDX_STEPUP: r[3:0] = {p[5], p[4], 1'b0, p[3]};
      `LS_IDX_MONITOR: r[4:0] = {p[2], 1'b0, p[1], 1'b0, p[0]};
      default: r = 32'h0000_0000;
    endcase
    return r;
  endfunction : exp_reg

  // ****************************************
  // Bus access
  // ****************************************
  // Holds the request until waitrequest is seen low, then releases
  task automatic bus_op(input logic w, input logic [7:0] idx, input logic [31:0] d,
                        output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_in);
    addr <= {idx, 2'b00};
    wdata <= d;
    rd <= ~w;
    wr <= w;
    do begin
      @(posedge clk_in);
      n++;
    end while (waitreq !== 1'b0 && n < 50);
    q = rdata;
    if (n >= 50) `CHK("bus answer", 1'b0, waitreq)
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus_op

  task automatic wr_reg(input logic [7:0] idx, input logic [31:0] d);
    logic [31:0] q;
    bus_op(1'b1, idx, d, q);
  endtask : wr_reg

  task automatic rd_chk(input string nm, input logic [7:0] idx, input logic [31:0] ex);
    logic [31:0] q;
    bus_op(1'b0, idx, 32'h0000_0000, q);
    `CHK(nm, ex, q)
  endtask : rd_chk

  task automatic check_all(input logic [15:0] p);
    rd_chk("global", `LS_IDX_GLOBAL, exp_reg(`LS_IDX_GLOBAL, p));
    rd_chk("stepdown", `LS_IDX_STEPDN, exp_reg(`LS_IDX_STEPDN, p));
    rd_chk("stepup", `LS_IDX_STEPUP, exp_reg(`LS_IDX_STEPUP, p));
    rd_chk("monitor", `LS_IDX_MONITOR, exp_reg(`LS_IDX_MONITOR, p));
  endtask : check_all

  task automatic apply(input logic [15:0] v);
    @(posedge clk_in);
    target <= v;
    repeat (10) @(posedge clk_in);
  endtask : apply

  task automatic irq_chk(input string nm, input logic ex);
    repeat (2) @(posedge clk_in);
    @(negedge clk_in);
    `CHK(nm, ex, irq)
  endtask : irq_chk

  // ****************************************
  // Tests
  // ****************************************
  initial begin
    rst_in = 1'b1;
    ce_in = 1'b1;
    rd = 1'b0;
    wr = 1'b0;
    addr = 10'h000;
    wdata = 32'h0000_0000;
    target = 16'h0000;
    repeat (20) @(posedge clk_in);
    rst_in <= 1'b0;

    check_all(16'h0000);
    rd_chk("mask reset", `LS_IDX_MASK, 32'h0000_0000);
    $display("test reset_values done");

    // Each pin alone, then all, then back to zero: live, never latched
    for (int i = 0; i < 16; i++) begin
      apply(16'h0001 << i);
      check_all(16'h0001 << i);
    end
    apply(16'hFFFF);
    check_all(16'hFFFF);
    apply(16'h0000);
    check_all(16'h0000);
    $display("test pin_mapping done");

    // Writes to read-only places, repeated reads, unmapped address
    apply(16'hA5C3);
    for (int k = 0; k < 4; k++) wr_reg(8'h25 + k[7:0], 32'hFFFF_FFFF);
    wr_reg(8'hFF, 32'hFFFF_FFFF);
    check_all(16'hA5C3);
    check_all(16'hA5C3);
    rd_chk("unmapped", 8'hFF, 32'h0000_0000);
    $display("test read_only done");

    // Events stay quiet on the line while masked, then raise and clear
    irq_chk("irq all masked", 1'b0);
    wr_reg(`LS_IDX_EVENT, 32'h0000_000F);
    rd_chk("events cleared", `LS_IDX_EVENT, 32'h0000_0000);
    wr_reg(`LS_IDX_MASK, 32'h1 << `LS_EVT_MONITOR);
    rd_chk("mask value", `LS_IDX_MASK, 32'h1 << `LS_EVT_MONITOR);
    irq_chk("irq idle", 1'b0);
    apply(16'hA5C2);
    rd_chk("monitor event", `LS_IDX_EVENT, 32'h1 << `LS_EVT_MONITOR);
    irq_chk("irq monitor", 1'b1);
    apply(16'hA583);
    wr_reg(`LS_IDX_EVENT, 32'h1 << `LS_EVT_MONITOR);
    irq_chk("irq stepdown masked", 1'b0);
    rd_chk("stepdown event", `LS_IDX_EVENT, 32'h1 << `LS_EVT_STEPDN);
    wr_reg(`LS_IDX_MASK, 32'h1 << `LS_EVT_STEPDN);
    irq_chk("irq stepdown", 1'b1);
    wr_reg(`LS_IDX_EVENT, 32'h1 << `LS_EVT_STEPDN);
    irq_chk("irq cleared", 1'b0);
    rd_chk("events empty", `LS_IDX_EVENT, 32'h0000_0000);
    $display("test interrupt done");

    // Enable low freezes the images; a mid-run reset zeroes them at once
    @(posedge clk_in);
    ce_in <= 1'b0;
    target <= 16'h5A3C;
    repeat (10) @(posedge clk_in);
    ce_in <= 1'b1;
    rd_chk("global frozen", `LS_IDX_GLOBAL, exp_reg(`LS_IDX_GLOBAL, 16'hA583));
    repeat (10) @(posedge clk_in);
    check_all(16'h5A3C);
    rst_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    rst_in <= 1'b0;
    rd_chk("global after reset", `LS_IDX_GLOBAL, 32'h0000_0000);
    rd_chk("mask after reset", `LS_IDX_MASK, 32'h0000_0000);
    irq_chk("irq after reset", 1'b0);
    repeat (10) @(posedge clk_in);
    check_all(16'h5A3C);
    $display("test enable_and_reset done");

    end_sim();
  end
endmodule : pmic_live_status_registers_tb_top
